// file: design/lccv_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts.
// Assumes: One 100 MHz clock; register addresses are 7 bits wide in a 16-bit serial frame.
// Notes: Times are kept in their own unit; cycle counts derive from them.
`ifndef LCCV_REGS_SVH
`define LCCV_REGS_SVH

// Register addresses
`define LCCV_ADDR_FUNC_CTRL 7'h00
`define LCCV_ADDR_GATE_SUP 7'h01
`define LCCV_ADDR_CH1_ON 7'h20
`define LCCV_ADDR_CH1_OFF 7'h21
`define LCCV_ADDR_CH2_ON 7'h22
`define LCCV_ADDR_CH2_OFF 7'h23

// Function control fields
`define LCCV_FC_LINK_ALIVE 7
`define LCCV_FC_CLR_ERR 6
`define LCCV_FC_DIM_EN1 1
`define LCCV_FC_WR_MASK 8'hC6
`define LCCV_FC_RST 8'h00

// Gate supply codes
`define LCCV_GATE_RST 8'hA6
`define LCCV_GATE_MIN_CODE 8'h5D
`define LCCV_GATE_MAX_CODE 8'hA6

// Capture reset value, zero volts
`define LCCV_CAP_RST 8'h00

// Serial frame
`define LCCV_FRAME_BITS 16
`define LCCV_ADDR_LAST_BIT 7

// Synchroniser lanes
`define LCCV_SYN_SCLK 0
`define LCCV_SYN_CS_N 1
`define LCCV_SYN_MOSI 2
`define LCCV_SYN_DIM1 3
`define LCCV_SYN_SUPPLY 5
`define LCCV_SYN_RST 6'h02

// Timing
`define LCCV_CLK_PERIOD_NS 10
`define LCCV_MEAS_PER_US 100
`define LCCV_STATIC_HOLD_US 1000
`define LCCV_MEAS_CYC ((`LCCV_MEAS_PER_US * 1000) / `LCCV_CLK_PERIOD_NS)
`define LCCV_STATIC_CYC ((`LCCV_STATIC_HOLD_US * 1000) / `LCCV_CLK_PERIOD_NS)

`endif

// file: design/lccv_pkg.sv
// Purpose: Types for the LED channel control and voltage capture block.
// Assumes: Constants live in lccv_regs.svh.
// Notes: All module state is one packed struct.
package lccv_pkg;

	// Serial port states, one-hot
	typedef enum logic [2:0] {
		st_idle = 3'h1,
		st_addr = 3'h2,
		st_data = 3'h4
	} lccv_spi_st_t;

	// Measurement codes from the converter, one per channel
	typedef struct packed {
		logic [1:0][7:0] code;
	} lccv_meas_t;

	// Whole state of the block
	typedef struct packed {
		lccv_spi_st_t spi_st;
		logic [4:0] bit_cnt;
		logic [15:0] rx;
		logic [7:0] tx;
		logic miso;
		logic [5:0] s1;
		logic [5:0] s2;
		logic [5:0] s3;
		logic [5:0] filt;
		logic [5:0] filt_d;
		logic [7:0] fc;
		logic [7:0] gate_code;
		logic [1:0][7:0] latest;
		logic [1:0][7:0] on_v;
		logic [1:0][7:0] off_v;
		logic [1:0][31:0] meas_cnt;
		logic [1:0][31:0] hold_cnt;
		logic err;
		logic bsuv;
		logic fsil;
		logic [1:0] gate;
	} lccv_state_t;

endpackage

// file: design/lccv_top.sv
// Purpose: Channel gating, output voltage capture and control registers of a
//          two-channel LED driver, reached over a 16-bit serial port.
// Assumes: Serial clock, select, data and the dimming and supply pins are asynchronous;
//          fault_in and meas_in come from logic on mclk.
// Notes: Frame is rw, 7-bit address, 8-bit data, msb first, sampled on rising sclk.
`timescale 1ns/100ps
`include "lccv_regs.svh"

module lccv_top #(
	parameter int MEAS_CYC = `LCCV_MEAS_CYC,
	parameter int STATIC_CYC = `LCCV_STATIC_CYC
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	input wire logic dimming_pin_1,
	input wire logic dimming_pin_2,
	input wire logic input_supply_ok,
	input wire logic fault_in,
	input wire lccv_pkg::lccv_meas_t meas_in,
	output logic [1:0] gate_drive_out,
	output logic [7:0] gate_supply_level,
	output logic bootstrap_undervoltage,
	output logic fail_silent
);
	import lccv_pkg::*;

	localparam lccv_state_t ST_RST = '{
		spi_st: st_idle,
		s1: `LCCV_SYN_RST,
		s2: `LCCV_SYN_RST,
		s3: `LCCV_SYN_RST,
		filt: `LCCV_SYN_RST,
		filt_d: `LCCV_SYN_RST,
		fc: `LCCV_FC_RST,
		gate_code: `LCCV_GATE_RST,
		default: '0
	};

	lccv_state_t st_r;
	lccv_state_t st_nxt;
	logic [5:0] raw;
	logic [5:0] rise;
	logic [5:0] fall;
	logic wr_en;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;
	logic [6:0] rd_addr;
	logic [7:0] rd_data;
	logic bs_set;
	logic clr_go;
	logic [1:0] strobe;

	// Raw pin lanes into the synchroniser
	assign raw = {input_supply_ok, dimming_pin_2, dimming_pin_1, spi_mosi, spi_cs_n, spi_sclk};

	// Register read mux; unmapped addresses read zero
	function automatic logic [7:0] rd_mux(input logic [6:0] a, input lccv_state_t s);
		logic [7:0] d;
		d = 8'h00;
		if (a == `LCCV_ADDR_FUNC_CTRL) begin
			d = s.fc & `LCCV_FC_WR_MASK;
		end else if (a == `LCCV_ADDR_GATE_SUP) begin
			d = s.gate_code;
		end else if (a == `LCCV_ADDR_CH1_ON) begin
			d = s.on_v[0];
		end else if (a == `LCCV_ADDR_CH1_OFF) begin
			d = s.off_v[0];
		end else if (a == `LCCV_ADDR_CH2_ON) begin
			d = s.on_v[1];
		end else if (a == `LCCV_ADDR_CH2_OFF) begin
			d = s.off_v[1];
		end
		return d;
	endfunction

	// Next-state logic
	always_comb begin
		st_nxt = st_r;
		wr_en = 1'b0;
		wr_addr = st_r.rx[13:7];
		wr_data = {st_r.rx[6:0], st_r.filt[`LCCV_SYN_MOSI]};
		rd_addr = {st_r.rx[5:0], st_r.filt[`LCCV_SYN_MOSI]};
		rd_data = rd_mux(rd_addr, st_r);
		rise = st_r.filt & ~st_r.filt_d;
		fall = ~st_r.filt & st_r.filt_d;
		strobe = 2'b00;

		// Three-stage pin synchroniser; a level counts once stages two and three agree
		st_nxt.s1 = raw;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.filt_d = st_r.filt;
		for (int b = 0; b < 6; b++) begin
			if (st_r.s2[b] == st_r.s3[b]) begin
				st_nxt.filt[b] = st_r.s3[b];
			end
		end

		// Serial slave; select rising aborts any unfinished frame
		case (st_r.spi_st)
			st_idle: begin
				st_nxt.miso = 1'b0;
				if (fall[`LCCV_SYN_CS_N]) begin
					st_nxt.spi_st = st_addr;
					st_nxt.bit_cnt = 5'h00;
				end
			end
			st_addr: begin
				if (st_r.filt[`LCCV_SYN_CS_N]) begin
					st_nxt.spi_st = st_idle;
				end else if (rise[`LCCV_SYN_SCLK]) begin
					st_nxt.rx = {st_r.rx[14:0], st_r.filt[`LCCV_SYN_MOSI]};
					st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
					if (st_r.bit_cnt == 5'(`LCCV_ADDR_LAST_BIT)) begin
						// Whole byte loads here; the next sclk fall puts bit 7 out
						// so the master finds it at the first data rise
						st_nxt.tx = rd_data;
						st_nxt.spi_st = st_data;
					end
				end
			end
			st_data: begin
				if (st_r.filt[`LCCV_SYN_CS_N]) begin
					st_nxt.spi_st = st_idle;
				end else if (rise[`LCCV_SYN_SCLK]) begin
					st_nxt.rx = {st_r.rx[14:0], st_r.filt[`LCCV_SYN_MOSI]};
					st_nxt.bit_cnt = st_r.bit_cnt + 5'h01;
					if (st_r.bit_cnt == 5'(`LCCV_FRAME_BITS - 1)) begin
						wr_en = st_r.rx[14];
						st_nxt.spi_st = st_idle;
					end
				end else if (fall[`LCCV_SYN_SCLK]) begin
					st_nxt.miso = st_r.tx[7];
					st_nxt.tx = {st_r.tx[6:0], 1'b0};
				end
			end
			default: begin
				st_nxt.spi_st = st_idle;
			end
		endcase

		// Error handling; a new error in the same cycle defers the clear
		bs_set = st_r.filt[`LCCV_SYN_SUPPLY] && (st_r.gate_code > `LCCV_GATE_MAX_CODE);
		clr_go = st_r.fc[`LCCV_FC_CLR_ERR] && (st_r.err || st_r.bsuv) && !fault_in && !bs_set;
		if (clr_go) begin
			st_nxt.err = 1'b0;
			st_nxt.bsuv = 1'b0;
			st_nxt.fc[`LCCV_FC_CLR_ERR] = 1'b0;
		end
		if (fault_in) begin
			st_nxt.err = 1'b1;
		end
		if (bs_set) begin
			st_nxt.bsuv = 1'b1;
		end

		// Register writes; capture registers and unmapped addresses ignore writes
		if (wr_en) begin
			if (wr_addr == `LCCV_ADDR_FUNC_CTRL) begin
				st_nxt.fc = wr_data & `LCCV_FC_WR_MASK;
			end else if (wr_addr == `LCCV_ADDR_GATE_SUP) begin
				st_nxt.gate_code = wr_data;
			end
		end

		// Per-channel measurement, capture and gating
		for (int c = 0; c < 2; c++) begin
			if (st_r.meas_cnt[c] == 32'(MEAS_CYC - 1)) begin
				st_nxt.meas_cnt[c] = 32'h0000_0000;
				strobe[c] = 1'b1;
			end else begin
				st_nxt.meas_cnt[c] = st_r.meas_cnt[c] + 32'h0000_0001;
			end
			if (st_r.filt[`LCCV_SYN_SUPPLY]) begin
				if (strobe[c]) begin
					st_nxt.latest[c] = meas_in.code[c];
				end
				if (fall[`LCCV_SYN_DIM1 + c]) begin
					st_nxt.on_v[c] = st_r.latest[c];
				end else if (rise[`LCCV_SYN_DIM1 + c]) begin
					st_nxt.off_v[c] = st_r.latest[c];
				end else if (st_r.hold_cnt[c] == 32'(STATIC_CYC - 1)) begin
					st_nxt.on_v[c] = st_r.latest[c];
					st_nxt.off_v[c] = st_r.latest[c];
				end
			end else begin
				st_nxt.latest[c] = st_r.latest[c];
			end
			if (rise[`LCCV_SYN_DIM1 + c] || fall[`LCCV_SYN_DIM1 + c]) begin
				st_nxt.hold_cnt[c] = 32'h0000_0000;
			end else if (st_r.hold_cnt[c] == 32'(STATIC_CYC - 1)) begin
				st_nxt.hold_cnt[c] = 32'h0000_0000;
			end else begin
				st_nxt.hold_cnt[c] = st_r.hold_cnt[c] + 32'h0000_0001;
			end
			// Gate runs only with pin high, enable set, supply good and no error
			st_nxt.gate[c] = st_r.filt[`LCCV_SYN_DIM1 + c]
				&& st_r.fc[`LCCV_FC_DIM_EN1 + c]
				&& st_r.filt[`LCCV_SYN_SUPPLY]
				&& !st_r.err && !st_r.bsuv;
		end

		// Fail-silent flag registered from the next error state
		st_nxt.fsil = st_nxt.err | st_nxt.bsuv;
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from state
	assign spi_miso = st_r.miso;
	assign gate_drive_out = st_r.gate;
	assign gate_supply_level = st_r.gate_code;
	assign bootstrap_undervoltage = st_r.bsuv;
	assign fail_silent = st_r.fsil;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	// Checks on gating, capture, error flags and the link-alive bit
	gate_dis_off_a: assert property (!st_r.fc[1] |=> !st_r.gate[0])
		else $error("channel one gate on while disabled");
	gate_run_a: assert property ((st_r.filt[3] && st_r.fc[1] && st_r.filt[5]
		&& !st_r.err && !st_r.bsuv) |=> st_r.gate[0])
		else $error("channel one gate not started");
	gate_stop_a: assert property (!st_r.filt[4] |=> !st_r.gate[1])
		else $error("channel two gate still on with pin low");
	supply_gate_a: assert property (!st_r.filt[5] |=> st_r.gate == 2'b00)
		else $error("gate on without supply");
	cap_on_a: assert property ((st_r.filt[5] && fall[3]) |=> st_r.on_v[0] == $past(st_r.latest[0]))
		else $error("on capture wrong");
	cap_off_a: assert property ((st_r.filt[5] && rise[4]) |=> st_r.off_v[1] == $past(st_r.latest[1]))
		else $error("off capture wrong");
	cap_freeze_a: assert property (!st_r.filt[5] |=> $stable(st_r.on_v) && $stable(st_r.off_v)
		&& $stable(st_r.latest))
		else $error("capture updated without supply");
	meas_period_a: assert property ($changed(st_r.latest[0]) |-> $past(strobe[0]))
		else $error("sample outside period strobe");
	clr_drop_a: assert property ((clr_go && !wr_en) |=> !st_r.fc[6] && !st_r.err && !st_r.bsuv)
		else $error("clear request not completed");
	clr_keep_a: assert property ((st_r.fc[6] && !st_r.err && !st_r.bsuv && !fault_in && !bs_set
		&& !wr_en) |=> st_r.fc[6])
		else $error("clear request dropped without error");
	bsuv_raise_a: assert property ((st_r.filt[5] && st_r.gate_code > 8'hA6) |=> st_r.bsuv)
		else $error("bad gate code not flagged");
	link_alive_a: assert property ((wr_en && wr_addr == 7'h00) |=> st_r.fc[7] == $past(wr_data[7]))
		else $error("link-alive bit not stored");

	gate_on_c: cover property (st_r.gate[0] && st_r.gate[1]);
	edge_cap_c: cover property (st_r.filt[5] && fall[3]);
	static_ref_c: cover property (st_r.filt[5] && st_r.hold_cnt[0] == 32'(STATIC_CYC - 1));
	clr_done_c: cover property (clr_go);

endmodule

// file: verif/lccv_mcu.sv
// Purpose: Controller model that runs 16-bit serial frames into the block.
// Assumes: Mode 0, msb first, half period of 8 mclk, select high time of 16 mclk.
// Notes: Serial clock stands low outside frames; data line inverts once released.
`timescale 1ns/100ps

module lccv_mcu (
	input wire logic mclk,
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	// Idle lines at time zero
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b1;
	end

	// One frame: rw, 7-bit address, 8 data bits; read data taken at each of the eight data rises
	task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] f;
		f = {wr, a, d};
		q = 8'h00;
		cs_n = 1'b0;
		repeat (8) @(negedge mclk);
		for (int i = 15; i >= 0; i--) begin
			mosi = f[i];
			repeat (8) @(negedge mclk);
			sclk = 1'b1;
			if (i < 8) begin
				q = {q[6:0], miso};
			end
			repeat (8) @(negedge mclk);
			sclk = 1'b0;
		end
		mosi = ~mosi; // Released line shows no stale value
		repeat (8) @(negedge mclk);
		cs_n = 1'b1;
		repeat (16) @(negedge mclk);
	endtask
endmodule

// file: verif/led_channel_ctrl_and_vmeas_bench.sv
// Purpose: Self-checking bench for gating, capture and control registers.
// Assumes: Short measurement and hold counts; all stimulus on falling mclk.
// Notes: Reset and gate-code expected values come from the register constants; the rest are literals.
`timescale 1ns/100ps
`include "lccv_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end

module led_channel_ctrl_and_vmeas_bench;
	import lccv_pkg::*;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic sclk, cs_n, mosi, miso, bsuv, fsil;
	logic dim1 = 1'b0;
	logic dim2 = 1'b0;
	logic sup_ok = 1'b1;
	logic fault = 1'b0;
	lccv_meas_t meas = '0;
	logic [1:0] gate;
	logic [7:0] gsl;
	int mismatches = 0;
	int comparisons = 0;
	int cyc = 0;

	// Clock, 10 ns period
	always #5 mclk = ~mclk;

	lccv_top #(.MEAS_CYC(20), .STATIC_CYC(2000)) u_dut (.mclk(mclk), .nrst(nrst),
		.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
		.dimming_pin_1(dim1), .dimming_pin_2(dim2), .input_supply_ok(sup_ok),
		.fault_in(fault), .meas_in(meas), .gate_drive_out(gate),
		.gate_supply_level(gsl), .bootstrap_undervoltage(bsuv), .fail_silent(fsil));

	lccv_mcu u_mcu (.mclk(mclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

	// Register access over the serial port
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		u_mcu.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] q;
		u_mcu.xfer(1'b0, a, 8'h00, q);
		`CHK(q, e)
	endtask
	task automatic cy(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic done(input string s);
		$display("test %s done", s);
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Hang guard
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			final_report();
		end
	end

	// Main sequence
	initial begin
		cy(6);
		nrst = 1'b1;
		cy(4);
		rd(`LCCV_ADDR_FUNC_CTRL, `LCCV_FC_RST);
		rd(`LCCV_ADDR_GATE_SUP, `LCCV_GATE_RST);
		for (int i = 0; i < 4; i++) rd(`LCCV_ADDR_CH1_ON + 7'(i), `LCCV_CAP_RST);
		wr(`LCCV_ADDR_FUNC_CTRL, 8'h80);
		rd(`LCCV_ADDR_FUNC_CTRL, 8'h80);
		done("reset_link");
		// Dimming pins against enable bits
		dim1 = 1'b1;
		dim2 = 1'b1;
		cy(10);
		`CHK(gate, 2'b00)
		wr(`LCCV_ADDR_FUNC_CTRL, 8'h82);
		`CHK(gate, 2'b01)
		wr(`LCCV_ADDR_FUNC_CTRL, 8'h86);
		`CHK(gate, 2'b11)
		dim1 = 1'b0;
		cy(10);
		`CHK(gate, 2'b10)
		dim1 = 1'b1;
		cy(10);
		`CHK(gate, 2'b11)
		done("gating");
		// Captures keyed to dimming edges and to the static hold
		meas.code = {8'h5A, 8'h3C};
		cy(30);
		dim1 = 1'b0;
		dim2 = 1'b0;
		cy(10);
		rd(`LCCV_ADDR_CH1_ON, 8'h3C);
		rd(`LCCV_ADDR_CH2_ON, 8'h5A);
		meas.code = {8'h21, 8'h12};
		cy(30);
		dim1 = 1'b1;
		dim2 = 1'b1;
		cy(10);
		rd(`LCCV_ADDR_CH1_OFF, 8'h12);
		rd(`LCCV_ADDR_CH2_OFF, 8'h21);
		wr(`LCCV_ADDR_CH1_ON, 8'hFF);
		rd(`LCCV_ADDR_CH1_ON, 8'h3C);
		rd(7'h10, 8'h00);
		meas.code = {8'h66, 8'h77};
		cy(2100);
		for (int i = 0; i < 4; i++) rd(`LCCV_ADDR_CH1_ON + 7'(i), i < 2 ? 8'h77 : 8'h66);
		done("capture");
		// Supply loss freezes captures and turns both gates off
		sup_ok = 1'b0;
		cy(10);
		meas.code = {8'h02, 8'h01};
		cy(20);
		`CHK(gate, 2'b00)
		dim1 = 1'b0;
		cy(10);
		rd(`LCCV_ADDR_CH1_ON, 8'h77);
		rd(`LCCV_ADDR_CH1_OFF, 8'h77);
		sup_ok = 1'b1;
		dim1 = 1'b1;
		cy(10);
		`CHK(gate, 2'b11)
		done("supply");
		// Gate supply code, out of range on purpose, then error clear
		wr(`LCCV_ADDR_GATE_SUP, `LCCV_GATE_MIN_CODE);
		rd(`LCCV_ADDR_GATE_SUP, `LCCV_GATE_MIN_CODE);
		`CHK(gsl, `LCCV_GATE_MIN_CODE)
		`CHK(bsuv, 1'b0)
		wr(`LCCV_ADDR_GATE_SUP, 8'hB0);
		cy(4);
		`CHK({bsuv, fsil, gate}, 4'hC)
		wr(`LCCV_ADDR_GATE_SUP, `LCCV_GATE_MAX_CODE);
		wr(`LCCV_ADDR_FUNC_CTRL, 8'hC6);
		`CHK({bsuv, fsil, gate}, 4'h3)
		rd(`LCCV_ADDR_FUNC_CTRL, 8'h86);
		wr(`LCCV_ADDR_FUNC_CTRL, 8'hC6);
		rd(`LCCV_ADDR_FUNC_CTRL, 8'hC6);
		fault = 1'b1;
		cy(1);
		fault = 1'b0;
		cy(4);
		`CHK(fsil, 1'b0)
		rd(`LCCV_ADDR_FUNC_CTRL, 8'h86);
		done("errors");
		final_report();
	end
endmodule
